// ---- rtl/eeprom_seq_regs.svh ----
`ifndef EEPROM_SEQ_REGS_SVH
`define EEPROM_SEQ_REGS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define EE_CTRL_IDX       10'h007
`define EE_OPTIONS_IDX    10'h200
`define EE_ARRAY_BASE_IDX 10'h200
`define EE_CTRL_RESET     5'h00
`define EE_ERASED_BYTE    8'hff
`define EE_PROTECT_BIT    1

`endif

// ---- rtl/eeprom_seq_pkg.sv ----
package eeprom_seq_pkg;

    // ------------------------------------------------------------------------
    // control register layout, bits 4..0
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ERASE_NONE,
        ERASE_BYTE,
        ERASE_BLOCK,
        ERASE_BULK
    } erase_mode_e;

    typedef struct packed {
        logic        osc_en;
        erase_mode_e mode;
        logic        program_latch_ctl;
        logic        program_power_en;
    } ctrl_s;

endpackage

// ---- rtl/eeprom_erase_program_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_seq_regs.svh"

module eeprom_erase_program_sequencer
    import eeprom_seq_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [11:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             program_latch_ctl_o,
    output logic             program_power_en_o
);

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic is_upper(input logic [8:0] idx);
        return idx[8];
    endfunction

    function automatic logic is_array(input logic [11:0] addr);
        return addr[11:2] >= `EE_ARRAY_BASE_IDX;
    endfunction

    function automatic logic is_ctrl(input logic [11:0] addr);
        return addr[11:2] == `EE_CTRL_IDX;
    endfunction

    // ------------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------------
    logic [7:0] mem [512];   // nonvolatile cells: no reset on purpose
    ctrl_s      ctrl;
    logic       ack;
    logic       used;
    logic       captured;
    logic [8:0] cap_addr;
    logic [7:0] cap_data;
    logic       protect;
    logic       fire;
    logic       wr_take;
    logic       rd_take;
    logic [8:0] bus_idx;
    ctrl_s      wr_ctrl;

    assign bus_idx = avs_address_i[10:2];
    assign wr_ctrl = ctrl_s'(avs_writedata_i[4:0]);
    assign protect = mem[9'(`EE_OPTIONS_IDX - `EE_ARRAY_BASE_IDX)][`EE_PROTECT_BIT];

    // ------------------------------------------------------------------------
    // avalon slave: one wait state on every access
    // ------------------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign wr_take = avs_write_i && ack && avs_byteenable_i[0];
    assign rd_take = avs_read_i && !ack;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i || avs_write_i) && !ack;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_take) begin
            if (is_array(avs_address_i)) begin
                if (ctrl.program_latch_ctl) begin
                    avs_readdata_o <= {24'h00_0000, `EE_ERASED_BYTE};
                end else begin
                    avs_readdata_o <= {24'h00_0000, mem[bus_idx]};
                end
            end else if (is_ctrl(avs_address_i)) begin
                avs_readdata_o <= {27'h000_0000, ctrl};
            end else begin
                avs_readdata_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= ctrl_s'(`EE_CTRL_RESET);
        end else if (wr_take && is_ctrl(avs_address_i)) begin
            ctrl.osc_en            <= wr_ctrl.osc_en;
            ctrl.program_latch_ctl <= wr_ctrl.program_latch_ctl;
            if (!wr_ctrl.program_latch_ctl) begin
                ctrl.mode             <= ERASE_NONE;
                ctrl.program_power_en <= 1'b0;
            end else begin
                ctrl.mode             <= wr_ctrl.mode;
                // power only arms when the latch was already set
                ctrl.program_power_en <= wr_ctrl.program_power_en
                                         && ctrl.program_latch_ctl;
            end
        end
    end

    assign program_latch_ctl_o = ctrl.program_latch_ctl;
    assign program_power_en_o  = ctrl.program_power_en;

    // ------------------------------------------------------------------------
    // address/data capture and one-shot arming
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            captured <= 1'b0;
            cap_addr <= 9'h000;
            cap_data <= 8'h00;
        end else if (!ctrl.program_latch_ctl) begin
            captured <= 1'b0;
        end else if (wr_take && is_array(avs_address_i)
                     && !ctrl.program_power_en && !used) begin
            captured <= 1'b1;
            cap_addr <= bus_idx;
            cap_data <= avs_writedata_i[7:0];
        end
    end

    // a used arming stays spent until the latch drops: no silent second shot
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            used <= 1'b0;
        end else if (!ctrl.program_latch_ctl) begin
            used <= 1'b0;
        end else if (fire) begin
            used <= 1'b1;
        end
    end

    assign fire = ctrl.program_power_en && captured && !used;

    // ------------------------------------------------------------------------
    // array update; pump timing is left to software
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (fire) begin
            for (int i = 0; i < 512; i++) begin
                logic [8:0] ii;
                logic       ok;
                ii = 9'(i);
                ok = !(is_upper(ii) && !protect);
                if (ok) begin
                    unique case (ctrl.mode)
                        ERASE_NONE: begin
                            if (ii == cap_addr) begin
                                mem[i] <= mem[i] & cap_data;
                            end
                        end
                        ERASE_BYTE: begin
                            if (ii == cap_addr) begin
                                mem[i] <= `EE_ERASED_BYTE;
                            end
                        end
                        ERASE_BLOCK: begin
                            if (is_upper(ii) == is_upper(cap_addr)) begin
                                mem[i] <= `EE_ERASED_BYTE;
                            end
                        end
                        ERASE_BULK: begin
                            mem[i] <= `EE_ERASED_BYTE;
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_read_all_ones: assert property (
        ack && $past(avs_read_i) && is_array($past(avs_address_i))
        && $past(ctrl.program_latch_ctl) |-> avs_readdata_o[7:0] == 8'hff)
        else $error("array read while latched was not all ones");

    a_power_needs_latch: assert property (
        $rose(ctrl.program_power_en) |-> $past(ctrl.program_latch_ctl))
        else $error("power enabled without prior latch");

    a_latch_clears_all: assert property (
        !ctrl.program_latch_ctl |-> !ctrl.program_power_en && ctrl.mode == ERASE_NONE)
        else $error("latch clear left power or mode set");

    a_fire_powered: assert property (
        fire |-> $rose(ctrl.program_power_en) && ctrl.program_latch_ctl)
        else $error("array operation not on power rise");

    a_single_shot: assert property (
        fire |=> !fire [*2])
        else $error("second operation without latch clear");

    a_upper_locked: assert property (
        fire && !protect && cap_addr[8] && ctrl.mode != ERASE_BULK
        |=> mem[cap_addr] == $past(mem[cap_addr]))
        else $error("protected upper block changed");

    a_bulk_protect: assert property (
        fire && !protect && ctrl.mode == ERASE_BULK
        |=> mem[9'h1ff] == $past(mem[9'h1ff]) && mem[9'h001] == 8'hff)
        else $error("bulk erase ignored upper protect");

    a_byte_erase: assert property (
        fire && ctrl.mode == ERASE_BYTE && !(cap_addr[8] && !protect)
        |=> mem[cap_addr] == 8'hff)
        else $error("byte erase missed");

    a_block_erase: assert property (
        fire && ctrl.mode == ERASE_BLOCK && !(cap_addr[8] && !protect)
        |=> mem[{cap_addr[8], 8'h00}] == 8'hff && mem[{cap_addr[8], 8'hff}] == 8'hff)
        else $error("block erase missed");

    a_program_byte: assert property (
        fire && ctrl.mode == ERASE_NONE && !(cap_addr[8] && !protect)
        |=> mem[cap_addr] == ($past(mem[cap_addr]) & $past(cap_data)))
        else $error("programmed byte wrong");

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    // ------------------------------------------------------------------------
    // clock, reset, bus signals
    // ------------------------------------------------------------------------
    localparam logic [11:0] CTRL = 12'h01c;

    logic        clk = 1'b0;
    logic        rst;
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        latch;
    logic        power;
    int          checks = 0;
    int          n_fail = 0;

    always #25 clk = ~clk;

    eeprom_erase_program_sequencer u_eeprom_erase_program_sequencer (
        .ref_clk_i           (clk),
        .sys_rst_i           (rst),
        .avs_address_i       (address),
        .avs_read_i          (read),
        .avs_write_i         (write),
        .avs_writedata_i     (writedata),
        .avs_byteenable_i    (byteenable),
        .avs_readdata_o      (readdata),
        .avs_waitrequest_o   (waitrequest),
        .program_latch_ctl_o (latch),
        .program_power_en_o  (power)
    );

    // ------------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------------
    function automatic logic [11:0] arr(input logic [8:0] i);
        return {1'b1, i, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest seen low, released at that edge
    // a hang is left to the watchdog: no cycle count is assumed here
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk);
        address    <= a;
        write      <= wr;
        read       <= !wr;
        writedata  <= {24'h0, d};
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    // status pins change at the write edge; look mid-cycle once settled
    task automatic chk_pins(input logic [1:0] exp);
        @(negedge clk);
        checks++;
        if ({latch, power} !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t pins %b exp %b", $time, {latch, power}, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hf, q);
        chk(q, {24'h0, exp});
    endtask

    // latch+mode, array write, power on, then clear latch with power bit still set
    task automatic op(input logic [1:0] m, input logic [8:0] i, input logic [7:0] d);
        wr(CTRL, {4'h0, m, 2'b10});
        wr(arr(i), d);
        wr(CTRL, {4'h0, m, 2'b11});
        chk_pins(2'b11);
        rd_chk(arr(i), 8'hff);
        wr(CTRL, {4'h0, m, 2'b01});
        chk_pins(2'b00);
        rd_chk(CTRL, 8'h00);
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] q;
        rd_chk(CTRL, 8'h00);
        bus(1'b1, CTRL, 8'h12, 4'h0, q);
        rd_chk(CTRL, 8'h00);
        wr(CTRL, 8'h10);
        rd_chk(CTRL, 8'h10);
        wr(CTRL, 8'h00);
        rd_chk(12'h000, 8'h00);
        wr(CTRL, 8'h03);
        chk_pins(2'b10);
        rd_chk(CTRL, 8'h02);
        wr(CTRL, 8'h00);
    endtask

    task automatic t_erase_program;
        op(2'b01, 9'h000, 8'h00);
        rd_chk(arr(9'h000), 8'hff);
        op(2'b11, 9'h1ff, 8'h00);
        rd_chk(arr(9'h010), 8'hff);
        rd_chk(arr(9'h1ff), 8'hff);
        op(2'b00, 9'h010, 8'ha5);
        op(2'b00, 9'h011, 8'h5a);
        rd_chk(arr(9'h010), 8'ha5);
        // second attempt with latch still set must be ignored
        wr(CTRL, 8'h02);
        wr(arr(9'h012), 8'h00);
        wr(CTRL, 8'h03);
        wr(CTRL, 8'h02);
        wr(arr(9'h013), 8'h00);
        wr(CTRL, 8'h03);
        wr(CTRL, 8'h00);
        rd_chk(arr(9'h012), 8'h00);
        rd_chk(arr(9'h013), 8'hff);
        // no power, no energy
        wr(CTRL, 8'h02);
        wr(arr(9'h014), 8'h00);
        wr(CTRL, 8'h00);
        rd_chk(arr(9'h014), 8'hff);
        op(2'b01, 9'h010, 8'h00);
        rd_chk(arr(9'h010), 8'hff);
        rd_chk(arr(9'h011), 8'h5a);
    endtask

    task automatic t_block_protect;
        op(2'b00, 9'h020, 8'h00);
        op(2'b00, 9'h140, 8'h00);
        op(2'b10, 9'h1ff, 8'h00);
        rd_chk(arr(9'h140), 8'hff);
        rd_chk(arr(9'h020), 8'h00);
        op(2'b00, 9'h141, 8'h00);
        op(2'b00, 9'h000, 8'hfd);
        rd_chk(arr(9'h000), 8'hfd);
        op(2'b00, 9'h150, 8'h00);
        rd_chk(arr(9'h150), 8'hff);
        op(2'b01, 9'h141, 8'h00);
        rd_chk(arr(9'h141), 8'h00);
        op(2'b11, 9'h020, 8'h00);
        rd_chk(arr(9'h141), 8'h00);
        rd_chk(arr(9'h020), 8'hff);
    endtask

    // ------------------------------------------------------------------------
    // sequence, watchdog, verdict
    // ------------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rst        = 1'b1;
        address    = 12'h000;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
        byteenable = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk_pins(2'b00);
        t_regs;
        t_erase_program;
        t_block_protect;
        report_and_stop;
    end

    // about 114 accesses of 3 cycles each; ample margin
    initial begin
        #200000;
        n_fail++;
        report_and_stop;
    end

endmodule

`default_nettype wire
